// file: smb_host.sv
`include "smb_consts.svh"
`default_nettype none
module smb_host #(
	parameter logic [6:0] SADDR = `SMB_SADDR,
	parameter int HALF = (`SMB_SCL_HALF_NS * 1000 + `SMB_MCLK_PS - 1) / `SMB_MCLK_PS
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	smb_if.host bus,
	input wire logic i_cmd_valid,
	output logic o_cmd_ready,
	input wire smb_pkg::smb_op_type i_cmd_op,
	input wire logic [15:0] i_cmd_addr,
	input wire logic [5:0] i_cmd_len,
	input wire logic i_cmd_pec,
	output logic [5:0] o_wr_idx,
	input wire logic [7:0] i_wr_data,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	output logic o_done,
	output logic o_nack,
	output logic o_pec_err
);
	localparam logic [15:0] HALF_M1 = 16'(HALF - 1);
	localparam logic [15:0] MID = 16'(HALF / 2);

	smb_pkg::smb_host_state_type q;
	smb_pkg::smb_host_state_type n;

	// ==========================================
	// Frame plan per step
	function automatic smb_pkg::smb_plan_type plan(input smb_pkg::smb_op_type op,
		input logic [5:0] m, input logic [5:0] len, input logic pec, input logic [15:0] a,
		input logic [7:0] wd, input logic [7:0] crc);
		smb_pkg::smb_plan_type p;
		p.act = smb_pkg::A_STOP;
		p.b = {SADDR, 1'h0};
		p.dat = 1'h0;
		p.pec = 1'h0;
		case (op)
			smb_pkg::OP_SET_RAM: begin
				if (m == 6'h01) begin
					p.act = smb_pkg::A_TX;
					p.b = a[7:0];
				end
			end
			smb_pkg::OP_SET_NV: begin
				if (m == 6'h01 || m == 6'h02) begin
					p.act = smb_pkg::A_TX;
					p.b = (m == 6'h01) ? a[15:8] : a[7:0];
				end
			end
			smb_pkg::OP_BWR: begin
				p.act = smb_pkg::A_TX;
				if (m == 6'h01) begin
					p.b = `SMB_CMD_BWR;
				end else if (m == `SMB_K_SR) begin
					p.b = {2'h0, len};
				end else if (m < `SMB_K_DATA + len) begin
					p.b = wd;
					p.dat = 1'h1;
				end else if (m == `SMB_K_DATA + len && pec) begin
					p.b = crc;
					p.pec = 1'h1;
				end else begin
					p.act = smb_pkg::A_STOP;
				end
			end
			smb_pkg::OP_RCV: begin
				if (m == 6'h01) begin
					p.act = smb_pkg::A_RXN;
				end
			end
			smb_pkg::OP_BRD: begin
				if (m == 6'h01) begin
					p.act = smb_pkg::A_TX;
					p.b = `SMB_CMD_BRD;
				end else if (m == `SMB_K_SR) begin
					p.act = smb_pkg::A_SRTX;
					p.b = {SADDR, 1'h1};
				end else if (m <= `SMB_K_BRD_LAST) begin
					p.act = smb_pkg::A_RXA;
				end else if (m == `SMB_K_BRD_PEC && pec) begin
					p.act = smb_pkg::A_RXN;
					p.pec = 1'h1;
				end
			end
			default: begin
				p.act = smb_pkg::A_STOP;
			end
		endcase
		return p;
	endfunction: plan

	// ==========================================
	// Bit engine
	always_comb begin
		logic scl;
		logic sda;
		logic bitval;
		logic [7:0] b0;
		smb_pkg::smb_plan_type p;
		bitval = 1'h1;
		n = q;
		n.rd_valid = 1'h0;
		n.done = 1'h0;
		n.scl_sy = {q.scl_sy[0], bus.scl};
		n.sda_sy = {q.sda_sy[0], bus.sda};
		scl = q.scl_sy[1];
		sda = q.sda_sy[1];
		b0 = {SADDR, i_cmd_op == smb_pkg::OP_RCV};
		p = plan(q.op, q.k + 6'h01, q.len, q.pec, q.addr, i_wr_data, q.crc);
		if (q.slot == smb_pkg::S_BYTE) begin
			if (q.bitn == `SMB_BIT_ACK) begin
				bitval = q.rx ? q.ackbit : 1'h1;
			end else begin
				bitval = q.rx ? 1'h1 : q.sh[7];
			end
		end else begin
			bitval = (q.slot == smb_pkg::S_RS);
		end
		case (q.st)
			smb_pkg::H_IDLE: begin
				if (i_cmd_valid) begin
					n.op = i_cmd_op;
					n.addr = i_cmd_addr;
					n.len = i_cmd_len;
					n.pec = i_cmd_pec;
					n.k = 6'h00;
					n.widx = 6'h00;
					n.nack = 1'h0;
					n.pec_err = 1'h0;
					n.sh = b0;
					n.crc = smb_pkg::crc8(8'h00, b0);
					n.rx = 1'h0;
					n.ispec = 1'h0;
					n.slot = smb_pkg::S_BYTE;
					n.bitn = 4'h0;
					n.cnt = 16'h0000;
					n.st = smb_pkg::H_START;
				end
			end
			smb_pkg::H_START: begin
				n.sda_oe = 1'h1;
				n.cnt = q.cnt + 16'h0001;
				if (q.cnt == HALF_M1) begin
					n.cnt = 16'h0000;
					n.scl_oe = 1'h1;
					n.st = smb_pkg::H_LOW;
				end
			end
			smb_pkg::H_LOW: begin
				n.cnt = q.cnt + 16'h0001;
				if (q.cnt == MID) begin
					n.sda_oe = ~bitval;
				end
				if (q.cnt == HALF_M1) begin
					n.cnt = 16'h0000;
					n.scl_oe = 1'h0;
					n.st = smb_pkg::H_HIGH;
				end
			end
			smb_pkg::H_HIGH: begin
				if (scl) begin
					n.cnt = q.cnt + 16'h0001;
				end
				if (scl && q.cnt == HALF_M1) begin
					n.cnt = 16'h0000;
					n.scl_oe = 1'h1;
					n.st = smb_pkg::H_LOW;
					if (q.slot == smb_pkg::S_STOP) begin
						n.scl_oe = 1'h0;
						n.st = smb_pkg::H_FIN;
					end else if (q.slot == smb_pkg::S_RS) begin
						n.scl_oe = 1'h0;
						n.slot = smb_pkg::S_BYTE;
						n.st = smb_pkg::H_START;
					end else if (q.bitn != `SMB_BIT_ACK) begin
						n.sh = {q.sh[6:0], q.rx ? sda : 1'h0};
						n.bitn = q.bitn + 4'h1;
					end else begin
						n.bitn = 4'h0;
						n.k = q.k + 6'h01;
						if (!q.rx && sda) begin
							n.nack = 1'h1;
							n.slot = smb_pkg::S_STOP;
						end else begin
							if (q.rx) begin
								n.rd_valid = 1'h1;
								n.rd_data = q.sh;
								if (q.ispec) begin
									n.pec_err = (q.sh != q.crc);
								end else begin
									n.crc = smb_pkg::crc8(q.crc, q.sh);
								end
							end
							n.ispec = p.pec;
							case (p.act)
								smb_pkg::A_TX, smb_pkg::A_SRTX: begin
									n.sh = p.b;
									n.rx = 1'h0;
									if (!p.pec) begin
										n.crc = smb_pkg::crc8(q.crc, p.b);
									end
									if (p.dat) begin
										n.widx = q.widx + 6'h01;
									end
									if (p.act == smb_pkg::A_SRTX) begin
										n.slot = smb_pkg::S_RS;
									end
								end
								smb_pkg::A_RXA, smb_pkg::A_RXN: begin
									n.rx = 1'h1;
									n.ackbit = (p.act == smb_pkg::A_RXN);
								end
								default: begin
									n.slot = smb_pkg::S_STOP;
								end
							endcase
						end
					end
				end
			end
			smb_pkg::H_FIN: begin
				n.cnt = q.cnt + 16'h0001;
				if (q.cnt == HALF_M1) begin
					n.cnt = 16'h0000;
					n.sda_oe = 1'h0;
					n.done = 1'h1;
					n.st = smb_pkg::H_IDLE;
				end
			end
			default: begin
				n.st = smb_pkg::H_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign bus.h_scl_o = 1'h0;
	assign bus.h_scl_oe = q.scl_oe;
	assign bus.h_sda_o = 1'h0;
	assign bus.h_sda_oe = q.sda_oe;
	assign o_cmd_ready = (q.st == smb_pkg::H_IDLE);
	assign o_wr_idx = q.widx;
	assign o_rd_valid = q.rd_valid;
	assign o_rd_data = q.rd_data;
	assign o_done = q.done;
	assign o_nack = q.nack;
	assign o_pec_err = q.pec_err;
endmodule: smb_host
`default_nettype wire

// file: smb_consts.svh
`ifndef SMB_CONSTS_SVH
`define SMB_CONSTS_SVH
`define SMB_CMD_BWR 8'hfc
`define SMB_CMD_BRD 8'hfd
`define SMB_BRD_CNT 8'h20
`define SMB_BRD_LEN 6'h20
`define SMB_BWR_MAX 8'h20
`define SMB_RAM_TOP 16'h00df
`define SMB_NV_BASE 16'hf800
`define SMB_NV_TOP 16'hfbff
`define SMB_NV_HI_MIN 8'hf8
`define SMB_NV_HI_MAX 8'hfb
`define SMB_CRC_POLY 8'h07
`define SMB_FILL 8'hff
`define SMB_BIT_PRE 4'hf
`define SMB_BIT_LAST 4'h7
`define SMB_BIT_ACK 4'h8
`define SMB_SADDR 7'h2c
`define SMB_NV_PROG_US 250
`define SMB_LCLK_PS 6000
`define SMB_MCLK_PS 10000
`define SMB_SCL_HALF_NS 5000
`define SMB_K_DATA 6'h03
`define SMB_K_SR 6'h02
`define SMB_K_BRD_LAST 6'h23
`define SMB_K_BRD_PEC 6'h24
`endif

// file: smb_pkg.sv
`include "smb_consts.svh"
`default_nettype none
package smb_pkg;
	// ==========================================
	// Enumerations
	typedef enum logic [1:0] {D_IDLE, D_ADDR, D_RX, D_TX} smb_dst_type;
	typedef enum logic [2:0] {M_CMD, M_NVLO, M_COUNT, M_DATA, M_PEC, M_DONE} smb_mode_type;
	typedef enum logic [2:0] {OP_SET_RAM, OP_SET_NV, OP_BWR, OP_RCV, OP_BRD} smb_op_type;
	typedef enum logic [2:0] {H_IDLE, H_START, H_LOW, H_HIGH, H_FIN} smb_hst_type;
	typedef enum logic [1:0] {S_BYTE, S_STOP, S_RS} smb_slot_type;
	typedef enum logic [2:0] {A_TX, A_SRTX, A_RXA, A_RXN, A_STOP} smb_act_type;

	// ==========================================
	// State records
	typedef struct packed {
		logic [2:0] scl_sy;
		logic [2:0] sda_sy;
		smb_dst_type st;
		logic [3:0] bcnt;
		logic [7:0] sh;
		logic rw;
		logic mack;
		logic sda_oe;
		logic scl_oe;
		logic in_frame;
		logic brd;
		smb_mode_type mode;
		logic [5:0] cnt;
		logic [5:0] idx;
		logic [7:0] crc;
		logic [15:0] ptr;
		logic [19:0] tmr;
		logic we;
		logic [15:0] waddr;
		logic [7:0] wdata;
		logic pec_err;
	} smb_dev_state_type;

	typedef struct packed {
		smb_act_type act;
		logic [7:0] b;
		logic dat;
		logic pec;
	} smb_plan_type;

	typedef struct packed {
		logic [1:0] scl_sy;
		logic [1:0] sda_sy;
		smb_hst_type st;
		smb_slot_type slot;
		smb_op_type op;
		logic [5:0] k;
		logic [5:0] len;
		logic pec;
		logic [15:0] addr;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic rx;
		logic ackbit;
		logic ispec;
		logic [15:0] cnt;
		logic [7:0] crc;
		logic scl_oe;
		logic sda_oe;
		logic [5:0] widx;
		logic rd_valid;
		logic [7:0] rd_data;
		logic done;
		logic nack;
		logic pec_err;
	} smb_host_state_type;

	// ==========================================
	// Packet check byte
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ `SMB_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction: crc8
endpackage: smb_pkg
`default_nettype wire

// file: smb_if.sv
`default_nettype none
interface smb_if;
	logic h_scl_o;
	logic h_scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_scl_o;
	logic d_scl_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;
	// ==========================================
	// Wired-and with pull-up
	assign scl = ~((h_scl_oe & ~h_scl_o) | (d_scl_oe & ~d_scl_o));
	assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
	modport dev(input scl, input sda, output d_scl_o, output d_scl_oe, output d_sda_o,
		output d_sda_oe);
	modport host(input scl, input sda, output h_scl_o, output h_scl_oe, output h_sda_o,
		output h_sda_oe);
endinterface: smb_if
`default_nettype wire

// file: smb_dev.sv
`include "smb_consts.svh"
`default_nettype none
// ==========================================
module smb_dev #(
	parameter logic [6:0] SADDR = `SMB_SADDR,
	parameter int PROG_CYC = (`SMB_NV_PROG_US * 1000000 + `SMB_LCLK_PS - 1) / `SMB_LCLK_PS
) (
	input wire logic i_lclk,
	input wire logic i_rst,
	smb_if.dev bus,
	input wire logic i_pec_en,
	input wire logic i_erase_busy,
	output logic [15:0] o_mem_raddr,
	input wire logic [7:0] i_mem_rdata,
	output logic o_mem_we,
	output logic [15:0] o_mem_waddr,
	output logic [7:0] o_mem_wdata,
	output logic o_pec_err
);
	localparam logic [19:0] PROG_LD = 20'(PROG_CYC);

	smb_pkg::smb_dev_state_type q;
	smb_pkg::smb_dev_state_type n;

	// ==========================================
	// Protocol engine
	always_comb begin
		logic scl;
		logic sda;
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic ok;
		logic is_nv;
		logic load;
		logic ack;
		logic crcup;
		logic tend;
		logic tpec;
		logic tinc;
		logic [7:0] rd;
		logic [7:0] tb;
		logic [7:0] b;
		tb = 8'h00;
		n = q;
		n.we = 1'h0;
		n.pec_err = 1'h0;
		n.scl_sy = {q.scl_sy[1:0], bus.scl};
		n.sda_sy = {q.sda_sy[1:0], bus.sda};
		scl = q.scl_sy[1];
		sda = q.sda_sy[1];
		rise = scl & ~q.scl_sy[2];
		fall = ~scl & q.scl_sy[2];
		start = scl & q.scl_sy[2] & q.sda_sy[2] & ~sda;
		stop = scl & q.scl_sy[2] & ~q.sda_sy[2] & sda;
		load = 1'h0;
		ack = 1'h1;
		crcup = 1'h1;
		b = q.sh;
		ok = (q.ptr <= `SMB_RAM_TOP) || (q.ptr >= `SMB_NV_BASE && q.ptr <= `SMB_NV_TOP);
		is_nv = (q.ptr >= `SMB_NV_BASE);
		rd = ok ? i_mem_rdata : `SMB_FILL;
		tpec = q.brd && (q.idx > `SMB_BRD_LEN);
		tend = q.brd && (q.idx > `SMB_BRD_LEN + 6'h01 || (tpec && !i_pec_en));
		tinc = !(q.brd && q.idx == 6'h00) && !tpec;
		if (q.brd && q.idx == 6'h00) begin
			tb = `SMB_BRD_CNT;
		end else if (tpec) begin
			tb = q.crc;
		end else begin
			tb = rd;
		end
		if (q.tmr != 20'h00000) begin
			n.tmr = q.tmr - 20'h00001;
		end else begin
			n.scl_oe = 1'h0;
		end
		if (start) begin
			n.st = smb_pkg::D_ADDR;
			n.bcnt = `SMB_BIT_PRE;
			n.sda_oe = 1'h0;
			if (!q.in_frame) begin
				n.crc = 8'h00;
			end
			n.in_frame = 1'h1;
		end else if (stop) begin
			n.st = smb_pkg::D_IDLE;
			n.sda_oe = 1'h0;
			n.in_frame = 1'h0;
			n.brd = 1'h0;
			n.mode = smb_pkg::M_CMD;
		end else begin
			case (q.st)
				smb_pkg::D_ADDR, smb_pkg::D_RX: begin
					if (rise && q.bcnt < `SMB_BIT_ACK) begin
						n.sh = {q.sh[6:0], sda};
					end
					if (fall && q.bcnt == `SMB_BIT_PRE) begin
						n.bcnt = 4'h0;
					end else if (fall && q.bcnt < `SMB_BIT_LAST) begin
						n.bcnt = q.bcnt + 4'h1;
					end else if (fall && q.bcnt == `SMB_BIT_LAST) begin
						n.bcnt = `SMB_BIT_ACK;
						if (q.st == smb_pkg::D_ADDR) begin
							if (b[7:1] == SADDR && !i_erase_busy) begin
								n.sda_oe = 1'h1;
								n.rw = b[0];
								n.idx = 6'h00;
								n.crc = smb_pkg::crc8(q.crc, b);
								if (!b[0]) begin
									n.mode = smb_pkg::M_CMD;
									n.brd = 1'h0;
								end
							end else begin
								n.st = smb_pkg::D_IDLE;
							end
						end else begin
							case (q.mode)
								smb_pkg::M_CMD: begin
									n.mode = smb_pkg::M_DONE;
									if (b == `SMB_CMD_BWR) begin
										n.mode = smb_pkg::M_COUNT;
									end else if (b == `SMB_CMD_BRD) begin
										n.brd = 1'h1;
									end else if (b >= `SMB_NV_HI_MIN && b <= `SMB_NV_HI_MAX) begin
										n.ptr[15:8] = b;
										n.mode = smb_pkg::M_NVLO;
									end else if ({8'h00, b} <= `SMB_RAM_TOP) begin
										n.ptr = {8'h00, b};
										n.cnt = 6'h01;
										n.mode = smb_pkg::M_DATA;
									end else begin
										ack = 1'h0;
									end
								end
								smb_pkg::M_NVLO: begin
									n.ptr[7:0] = b;
									n.cnt = 6'h01;
									n.mode = smb_pkg::M_DATA;
								end
								smb_pkg::M_COUNT: begin
									if (b > `SMB_BWR_MAX) begin
										ack = 1'h0;
										n.mode = smb_pkg::M_DONE;
									end else begin
										n.cnt = b[5:0];
										n.mode = (b == 8'h00) ? smb_pkg::M_PEC : smb_pkg::M_DATA;
									end
								end
								smb_pkg::M_DATA: begin
									n.we = ok;
									n.waddr = q.ptr;
									n.wdata = b;
									n.ptr = q.ptr + 16'h0001;
									n.cnt = q.cnt - 6'h01;
									if (q.cnt == 6'h01) begin
										n.mode = smb_pkg::M_PEC;
									end
									if (ok && is_nv) begin
										n.tmr = PROG_LD;
									end
								end
								smb_pkg::M_PEC: begin
									crcup = 1'h0;
									ack = i_pec_en && (b == q.crc);
									n.pec_err = i_pec_en && (b != q.crc);
									n.mode = smb_pkg::M_DONE;
								end
								default: begin
									ack = 1'h0;
									crcup = 1'h0;
								end
							endcase
							n.sda_oe = ack;
							if (crcup) begin
								n.crc = smb_pkg::crc8(q.crc, b);
							end
						end
					end else if (fall && q.bcnt == `SMB_BIT_ACK) begin
						n.bcnt = 4'h0;
						n.sda_oe = 1'h0;
						if (q.st == smb_pkg::D_ADDR && q.rw) begin
							load = 1'h1;
						end else if (q.st == smb_pkg::D_ADDR) begin
							n.st = smb_pkg::D_RX;
						end
						if (q.tmr != 20'h00000) begin
							n.scl_oe = 1'h1;
						end
					end
				end
				smb_pkg::D_TX: begin
					if (rise && q.bcnt == `SMB_BIT_ACK) begin
						n.mack = sda;
					end
					if (fall && q.bcnt < `SMB_BIT_LAST) begin
						n.bcnt = q.bcnt + 4'h1;
						n.sh = {q.sh[6:0], 1'h0};
						n.sda_oe = ~q.sh[6];
					end else if (fall && q.bcnt == `SMB_BIT_LAST) begin
						n.bcnt = `SMB_BIT_ACK;
						n.sda_oe = 1'h0;
					end else if (fall) begin
						n.bcnt = 4'h0;
						if (q.mack) begin
							n.st = smb_pkg::D_IDLE;
						end else begin
							load = 1'h1;
						end
					end
				end
				default: begin
					n.sda_oe = 1'h0;
				end
			endcase
		end
		if (load && tend) begin
			n.st = smb_pkg::D_IDLE;
		end else if (load) begin
			n.st = smb_pkg::D_TX;
			n.sh = tb;
			n.sda_oe = ~tb[7];
			n.idx = q.idx + 6'h01;
			if (tinc) begin
				n.ptr = q.ptr + 16'h0001;
			end
			if (!tpec) begin
				n.crc = smb_pkg::crc8(q.crc, tb);
			end
		end
	end

	always_ff @(posedge i_lclk) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign bus.d_scl_o = 1'h0;
	assign bus.d_scl_oe = q.scl_oe;
	assign bus.d_sda_o = 1'h0;
	assign bus.d_sda_oe = q.sda_oe;
	assign o_mem_raddr = q.ptr;
	assign o_mem_we = q.we;
	assign o_mem_waddr = q.waddr;
	assign o_mem_wdata = q.wdata;
	assign o_pec_err = q.pec_err;
endmodule: smb_dev
`default_nettype wire

// file: smb_assertions.sv
`include "smb_consts.svh"
`default_nettype none
module smb_assertions #(
	parameter int PROG_CYC = 200
) (
	input wire logic i_lclk,
	input wire logic i_rst,
	input wire logic i_erase_busy,
	input wire logic scl,
	input wire logic sda,
	input wire logic d_scl_oe,
	input wire logic d_sda_oe
);
	// ==========================================
	// Frame tracking on the wire
	logic scl_ff, sda_ff, rise, start, stp, ack, own;
	logic [3:0] bitc_ff;
	logic [5:0] byc_ff;
	logic [7:0] sh_ff, adr_ff, cmd_ff, cnt_ff;
	assign rise = scl & ~scl_ff;
	assign start = scl & scl_ff & sda_ff & ~sda;
	assign stp = scl & scl_ff & ~sda_ff & sda;
	assign ack = rise && bitc_ff == 4'h8;
	assign own = adr_ff[7:1] == `SMB_SADDR && !adr_ff[0];
	always_ff @(posedge i_lclk) begin
		scl_ff <= scl;
		sda_ff <= sda;
		if (i_rst || stp) begin
			bitc_ff <= 4'h0;
			byc_ff <= 6'h00;
			cmd_ff <= 8'h00;
		end else if (start) begin
			bitc_ff <= 4'h0;
			byc_ff <= 6'h00;
		end else if (ack) begin
			bitc_ff <= 4'h0;
			byc_ff <= byc_ff + 6'h01;
			if (byc_ff == 6'h00) adr_ff <= sh_ff;
			if (byc_ff == 6'h01 && !adr_ff[0]) cmd_ff <= sh_ff;
			if (byc_ff == 6'h02) cnt_ff <= sh_ff;
		end else if (rise) begin
			bitc_ff <= bitc_ff + 4'h1;
			sh_ff <= {sh_ff[6:0], sda};
		end
	end
	// ==========================================
	// Checks
	default clocking cb @(posedge i_lclk); endclocking
	default disable iff (i_rst);
	a_own_addr_ack: assert property (ack && byc_ff == 6'h00 && sh_ff[7:1] == `SMB_SADDR
		&& !i_erase_busy |-> !sda) else $error("own address not acknowledged");
	a_busy_addr_nack: assert property (ack && byc_ff == 6'h00 && i_erase_busy |-> sda)
		else $error("address acknowledged while erasing");
	a_cmd_ack: assert property (ack && byc_ff == 6'h01 && own
		&& (sh_ff == 8'hfc || sh_ff == 8'hfd) |-> !sda) else $error("block command not acknowledged");
	a_bad_cmd_nack: assert property (ack && byc_ff == 6'h01 && own
		&& sh_ff >= 8'he0 && sh_ff <= 8'hf7 |-> sda) else $error("unmapped command acknowledged");
	a_count_limit: assert property (ack && byc_ff == 6'h02 && own && cmd_ff == 8'hfc
		|-> sda == (sh_ff > 8'h20)) else $error("block count answer wrong");
	a_block_data_ack: assert property (ack && own && cmd_ff == 8'hfc && byc_ff >= 6'h03
		&& byc_ff < cnt_ff + 8'h03 |-> !sda) else $error("block data byte not acknowledged");
	a_read_count: assert property (ack && byc_ff == 6'h01 && adr_ff[0] && cmd_ff == 8'hfd
		|-> sh_ff == 8'h20) else $error("block read count wrong");
	a_stretch_low: assert property ($rose(d_scl_oe) |-> $past(scl, 2) == 1'b0)
		else $error("stretch began while clock high");
	a_stretch_bound: assert property ($rose(d_scl_oe) |-> ##[1:PROG_CYC] !d_scl_oe)
		else $error("stretch too long");
	a_reset_release: assert property ($fell(i_rst) |-> !d_sda_oe && !d_scl_oe)
		else $error("lines held after reset");
endmodule: smb_assertions
`default_nettype wire

// file: tb_top.sv
`include "smb_consts.svh"
`default_nettype none
`define CHK(a, b) compare(64'(a), 64'(b));
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// Clocks, ends and checker
	localparam int PCYC = 200;
	logic i_mclk = 1'b0;
	logic lclk = 1'b0;
	logic i_rst = 1'b1;
	logic cv = 1'b0, pc = 1'b0, pec_en = 1'b0, busy = 1'b0;
	smb_pkg::smb_op_type op = smb_pkg::OP_SET_RAM;
	logic [15:0] ca = 16'h0000, raddr, waddr;
	logic [5:0] cl = 6'h00, widx;
	logic [7:0] wb [0:63];
	logic [7:0] mem [0:65535];
	logic [7:0] rf [0:65535];
	logic [7:0] rdat, wdat;
	logic rdy, rv, done, nack, hpe, we, dpe;
	logic [7:0] exp_rd [$];
	logic [23:0] exp_wr [$];
	int n_fail = 0, check_count = 0, cyc = 0, ptr = 0;
	always #5 i_mclk = ~i_mclk;
	initial begin
		#1.7;
		forever #3 lclk = ~lclk;
	end
	smb_if smb_if_inst();
	smb_host #(.HALF(16)) smb_host_inst(.i_mclk(i_mclk), .i_rst(i_rst), .bus(smb_if_inst),
		.i_cmd_valid(cv), .o_cmd_ready(rdy), .i_cmd_op(op), .i_cmd_addr(ca), .i_cmd_len(cl),
		.i_cmd_pec(pc), .o_wr_idx(widx), .i_wr_data(wb[widx]), .o_rd_valid(rv), .o_rd_data(rdat),
		.o_done(done), .o_nack(nack), .o_pec_err(hpe));
	smb_dev #(.PROG_CYC(PCYC)) smb_dev_inst(.i_lclk(lclk), .i_rst(i_rst), .bus(smb_if_inst),
		.i_pec_en(pec_en), .i_erase_busy(busy), .o_mem_raddr(raddr), .i_mem_rdata(mem[raddr]),
		.o_mem_we(we), .o_mem_waddr(waddr), .o_mem_wdata(wdat), .o_pec_err(dpe));
	smb_assertions #(.PROG_CYC(PCYC)) smb_assertions_inst(.i_lclk(lclk), .i_rst(i_rst),
		.i_erase_busy(busy), .scl(smb_if_inst.scl), .sda(smb_if_inst.sda),
		.d_scl_oe(smb_if_inst.d_scl_oe), .d_sda_oe(smb_if_inst.d_sda_oe));
	// ==========================================
	// Model helpers
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask: finish_test
	function automatic void compare(input logic [63:0] got, input logic [63:0] want);
		check_count++;
		if (got !== want) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, want);
		end
	endfunction: compare
	function automatic logic [7:0] fcs(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
		end
		return r;
	endfunction: fcs
	function automatic logic [7:0] peek(input int a);
		return (a <= 'h00df || (a >= 'hf800 && a <= 'hfbff)) ? rf[a] : 8'hff;
	endfunction: peek
	// ==========================================
	// Result monitors
	always @(posedge i_mclk) begin
		cyc++;
		if (rv === 1'b1) `CHK(rdat, exp_rd.size() ? exp_rd.pop_front() : 8'hxx)
		if (cyc == 90000) begin
			n_fail++;
			finish_test();
		end
	end
	always @(posedge lclk) begin
		if (we === 1'b1) begin
			mem[waddr] <= wdat;
			`CHK({waddr, wdat}, exp_wr.size() ? exp_wr.pop_front() : 24'hxxxxxx)
		end
		if (dpe !== 1'b0) `CHK(dpe, 1'b0)
	end
	// ==========================================
	// One host command with its expectations
	task automatic run(input smb_pkg::smb_op_type o, input int a, input int n, input logic p,
		input logic nk);
		logic [7:0] c;
		int t;
		@(negedge i_mclk);
		for (int i = 0; i < 64; i++) begin
			wb[i] = 8'($urandom);
		end
		c = fcs(fcs(fcs(8'h00, {`SMB_SADDR, 1'b0}), 8'hfd), {`SMB_SADDR, 1'b1});
		if (!nk) begin
			case (o)
				smb_pkg::OP_SET_RAM: ptr = a & 'hff;
				smb_pkg::OP_SET_NV: ptr = a;
				smb_pkg::OP_BWR: for (int i = 0; i < n; i++) begin
					exp_wr.push_back({ptr[15:0], wb[i]});
					rf[ptr] = wb[i];
					ptr++;
				end
				smb_pkg::OP_RCV: exp_rd.push_back(peek(ptr));
				default: begin
					exp_rd.push_back(8'h20);
					c = fcs(c, 8'h20);
					for (int i = 0; i < 32; i++) begin
						exp_rd.push_back(peek(ptr + i));
						c = fcs(c, peek(ptr + i));
					end
					if (p) exp_rd.push_back(c);
				end
			endcase
		end
		op = o;
		ca = a[15:0];
		cl = n[5:0];
		pc = p;
		pec_en = p;
		`CHK(rdy, 1'b1)
		cv = 1'b1;
		@(negedge i_mclk);
		cv = 1'b0;
		t = 0;
		while (done !== 1'b1 && t < 30000) begin
			@(negedge i_mclk);
			t++;
		end
		`CHK(done, 1'b1)
		`CHK(nack, nk)
		`CHK(hpe, 1'b0)
	endtask: run
	// ==========================================
	// Main sequence
	initial begin
		int p;
		int n;
		void'($urandom(98));
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'($urandom);
			rf[i] = mem[i];
		end
		repeat (10) @(negedge i_mclk);
		i_rst = 1'b0;
		repeat (4) @(negedge i_mclk);
		p = $urandom_range(0, 'hbf);
		n = $urandom_range(1, 32);
		// Volatile block write, follow-on read, block read
		run(smb_pkg::OP_SET_RAM, p, 0, 1'b0, 1'b0);
		run(smb_pkg::OP_BWR, 0, n, 1'b0, 1'b0);
		run(smb_pkg::OP_RCV, 0, 0, 1'b0, 1'b0);
		run(smb_pkg::OP_SET_RAM, p, 0, 1'b0, 1'b0);
		run(smb_pkg::OP_BRD, 0, 0, 1'b0, 1'b0);
		// Nonvolatile write with stretch, checked read
		// block inside store
		p = 'hf800 + $urandom_range(0, 'h3d0);
		run(smb_pkg::OP_SET_NV, p, 0, 1'b0, 1'b0);
		run(smb_pkg::OP_BWR, 0, 4, 1'b1, 1'b0);
		run(smb_pkg::OP_SET_NV, p, 0, 1'b0, 1'b0);
		run(smb_pkg::OP_BRD, 0, 0, 1'b1, 1'b0);
		// Refusals: long count, reserved command, erasing
		run(smb_pkg::OP_BWR, 0, 33, 1'b0, 1'b1);
		run(smb_pkg::OP_SET_RAM, 'he5, 0, 1'b0, 1'b1);
		busy = 1'b1;
		run(smb_pkg::OP_RCV, 0, 0, 1'b0, 1'b1);
		busy = 1'b0;
		run(smb_pkg::OP_SET_NV, p + 3, 0, 1'b0, 1'b0);
		run(smb_pkg::OP_RCV, 0, 0, 1'b0, 1'b0);
		repeat (20) @(negedge i_mclk);
		`CHK(exp_rd.size(), 0)
		`CHK(exp_wr.size(), 0)
		finish_test();
	end
endmodule: tb_top
`default_nettype wire
